/* File: rtl/sdp_top.sv */
`timescale 1ns/1ps
module sdp_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 32
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	import sdp_pkg::*;
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_q[AW-1:0]];

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wr_q <= '0;
		end else if (push) begin
			wr_q <= wr_q + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rd_q <= '0;
		end else if (pop) begin
			rd_q <= rd_q + 1'b1;
		end
	end
endmodule : sdp_fifo

module sdp_sync #(
	parameter logic INIT = 1'b0
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic async_in,
	output logic sync_out,
	output logic sync_prev
);
	import sdp_pkg::*;

	logic meta_q;
	logic sync_q;
	logic prev_q;

	// only sync_q reads meta_q, the one flop that may go metastable
	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q <= INIT;
			sync_q <= INIT;
			prev_q <= INIT;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign sync_out = sync_q;
	assign sync_prev = prev_q;
endmodule : sdp_sync

module sdp_top #(
	parameter int DEPTH = sdp_pkg::FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic sclk,
	input wire logic frame_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic [sdp_pkg::CODE_W-1:0] dac_code,
	input wire logic code_ready,
	output logic code_pending,
	output logic word_ready,
	output logic rise_edge_sel,
	output logic daisy_mode
);
	import sdp_pkg::*;

	// clock-domain state
	logic rst_link_q;
	logic rise_q;
	logic daisy_q;
	logic [CODE_W-1:0] dac_q;
	logic fs_sync;
	logic fs_prev;
	logic ts_sync;
	logic ts_prev;
	logic take;
	logic is_load;
	logic is_readback;
	logic is_rise;
	logic is_fall;
	logic is_daisy_on;
	logic is_daisy_off;
	logic [CODE_W-1:0] rb_code_q;
	sdp_word_t word_in;
	logic fifo_valid;
	logic [CODE_W-1:0] fifo_data;

	// link-domain state
	logic act_clk;
	logic frame_clr;
	logic [CNT_W-1:0] cnt_q;
	logic [WORD_W-1:0] shift_q;
	logic [WORD_W-1:0] word_q;
	logic tgl_q;
	logic rb_q;
	logic so_q;
	logic [WORD_W-1:0] shift_d;
	logic [WORD_W-1:0] rb_word;

	// reset reaches the link side as a level so a stopped sclk still clears
	always_ff @(posedge clock) begin
		rst_link_q <= rst;
	end

	// sample edge flips on decode: frame idle in daisy mode, but stand-alone decode can land while frame is still low
	assign act_clk = rise_q ? sclk : ~sclk;
	assign frame_clr = frame_n | rst_link_q;

	// readback frame preloads the code snapshot taken at decode
	assign rb_word = {{CTL_W{1'b0}}, rb_code_q};
	always_comb begin
		shift_d = {shift_q[WORD_W-2:0], serial_in};
		if (rb_q && cnt_q == '0) begin
			shift_d = {rb_word[WORD_W-2:0], serial_in};
		end
	end

	always_ff @(posedge act_clk or posedge frame_clr) begin
		if (frame_clr) begin
			cnt_q <= '0;
		end else if (cnt_q != CNT_SAT) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	always_ff @(posedge act_clk or posedge rst_link_q) begin
		if (rst_link_q) begin
			shift_q <= WORD_RST;
		end else if (!frame_n) begin
			shift_q <= shift_d;
		end
	end

	// word and its toggle only move on the 16th edge of a frame
	always_ff @(posedge act_clk or posedge rst_link_q) begin
		if (rst_link_q) begin
			word_q <= WORD_RST;
		end else if (!frame_n && cnt_q == LAST_BIT) begin
			word_q <= shift_d;
		end
	end

	always_ff @(posedge act_clk or posedge rst_link_q) begin
		if (rst_link_q) begin
			tgl_q <= TGL_RST;
		end else if (!frame_n && cnt_q == LAST_BIT) begin
			tgl_q <= ~tgl_q;
		end
	end

	always_ff @(posedge act_clk or posedge rst_link_q) begin
		if (rst_link_q) begin
			rb_q <= 1'b0;
		end else if (!frame_n && cnt_q == LAST_BIT) begin
			rb_q <= shift_d[WORD_W-1 -: CTL_W] == CTL_READBACK;
		end
	end

	// edge reselect while idle glitches act_clk; chained output must hold
	always_ff @(negedge act_clk or posedge rst_link_q) begin
		if (rst_link_q) begin
			so_q <= 1'b0;
		end else if (!frame_n) begin
			so_q <= shift_q[WORD_W-1];
		end
	end
	assign serial_out = so_q;

	// crossings: frame level and word toggle, two flops then edge detect
	sdp_sync #(
		.INIT(FRAME_IDLE)
	) u_frame_sync (
		.clock(clock),
		.rst(rst),
		.async_in(frame_n),
		.sync_out(fs_sync),
		.sync_prev(fs_prev)
	);

	sdp_sync #(
		.INIT(TGL_RST)
	) u_tgl_sync (
		.clock(clock),
		.rst(rst),
		.async_in(tgl_q),
		.sync_out(ts_sync),
		.sync_prev(ts_prev)
	);

	// word buses are read only once their frame or edge has settled
	always_comb begin
		if (daisy_q) begin
			take = fs_sync & ~fs_prev;
			word_in = sdp_word_t'(shift_q);
		end else begin
			take = ts_sync ^ ts_prev;
			word_in = sdp_word_t'(word_q);
		end
	end

	// one strobe per control code; unknown codes do nothing
	always_comb begin
		is_load = 1'b0;
		is_readback = 1'b0;
		is_rise = 1'b0;
		is_fall = 1'b0;
		is_daisy_on = 1'b0;
		is_daisy_off = 1'b0;
		if (take) begin
			case (word_in.ctl)
				CTL_LOAD: is_load = 1'b1;
				CTL_READBACK: is_readback = 1'b1;
				CTL_EDGE_RISE: is_rise = 1'b1;
				CTL_EDGE_FALL: is_fall = 1'b1;
				CTL_DAISY_ON: is_daisy_on = 1'b1;
				CTL_DAISY_OFF: is_daisy_off = 1'b1;
				default: is_load = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rise_q <= RISE_RST;
		end else if (is_rise) begin
			rise_q <= 1'b1;
		end else if (is_fall) begin
			rise_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			daisy_q <= DAISY_RST;
		end else if (is_daisy_on) begin
			daisy_q <= 1'b1;
		end else if (is_daisy_off) begin
			daisy_q <= 1'b0;
		end
	end

	// a full fifo drops the load; word_ready tells the system so
	sdp_fifo #(
		.WIDTH(CODE_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clock(clock),
		.rst(rst),
		.in_valid(is_load),
		.in_ready(word_ready),
		.in_data(word_in.code),
		.out_valid(fifo_valid),
		.out_ready(code_ready),
		.out_data(fifo_data)
	);

	always_ff @(posedge clock) begin
		if (rst) begin
			dac_q <= CODE_RST;
		end else if (fifo_valid && code_ready) begin
			dac_q <= fifo_data;
		end
	end

	// snapshot keeps the link from sampling dac_q while a pop moves it
	always_ff @(posedge clock) begin
		if (rst) begin
			rb_code_q <= CODE_RST;
		end else if (is_readback) begin
			rb_code_q <= dac_q;
		end
	end

	assign dac_code = dac_q;
	assign code_pending = fifo_valid;
	assign rise_edge_sel = rise_q;
	assign daisy_mode = daisy_q;
endmodule : sdp_top

/* File: rtl/sdp_pkg.sv */
// Function
// - sample data on falling edge after power-up
// - control word can select rising sample edge
// - sixteen-bit input shift register, one bit/edge
// - frame select low enables shifting and counting
// - stand-alone: latch word on 16th active edge
// - serial output changes on the opposite edge
// - shifted-out bits feed next device in chain
// - readback word returns converter code next frame
// - power-up clears shift register and all latches
// - word passes to a separate converter register
package sdp_pkg;
	localparam int WORD_W = 16;
	localparam int CODE_W = 12;
	localparam int CTL_W = 4;
	localparam int CNT_W = 5;
	localparam int FIFO_DEPTH = 32;
	localparam logic [CNT_W-1:0] LAST_BIT = 5'h0f;
	localparam logic [CNT_W-1:0] CNT_SAT = 5'h10;
	localparam logic [CTL_W-1:0] CTL_NOP = 4'h0;
	localparam logic [CTL_W-1:0] CTL_LOAD = 4'h1;
	localparam logic [CTL_W-1:0] CTL_READBACK = 4'h2;
	localparam logic [CTL_W-1:0] CTL_DAISY_ON = 4'h8;
	localparam logic [CTL_W-1:0] CTL_DAISY_OFF = 4'h9;
	localparam logic [CTL_W-1:0] CTL_EDGE_FALL = 4'ha;
	localparam logic [CTL_W-1:0] CTL_EDGE_RISE = 4'hb;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
	localparam logic RISE_RST = 1'b0;
	localparam logic DAISY_RST = 1'b0;
	localparam logic FRAME_IDLE = 1'b1;
	localparam logic TGL_RST = 1'b0;

	typedef struct packed {
		logic [CTL_W-1:0] ctl;
		logic [CODE_W-1:0] code;
	} sdp_word_t;
endpackage : sdp_pkg

/* File: verif/sdp_top_sva.sv */
`timescale 1ns/1ps
module sdp_top_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic sclk,
	input wire logic frame_n,
	input wire logic serial_out,
	input wire logic [sdp_pkg::CODE_W-1:0] dac_code,
	input wire logic code_ready,
	input wire logic code_pending,
	input wire logic word_ready,
	input wire logic rise_edge_sel,
	input wire logic daisy_mode
);
	import sdp_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence pop_s;
		code_ready && code_pending;
	endsequence
	a_reset_clear: assert property ($fell(rst) |->
		dac_code == CODE_RST && !code_pending && word_ready)
		else $error("outputs not cleared after reset");
	a_default_edge: assert property ($fell(rst) |->
		rise_edge_sel == RISE_RST && daisy_mode == DAISY_RST)
		else $error("mode not default after reset");
	a_code_held: assert property (
		!(code_ready && code_pending) |=> $stable(dac_code))
		else $error("code moved without a pop");
	a_pop_frees: assert property (pop_s |=> word_ready)
		else $error("full after a pop");
	// sclk is slow, so it still shows the launching level here
	a_out_edge: assert property (
		$changed(serial_out) |-> sclk != rise_edge_sel)
		else $error("serial out moved on the active edge");
	a_idle_quiet: assert property (
		frame_n [*3] |-> $stable(serial_out))
		else $error("serial out moved outside a frame");
	a_full_pending: assert property (!word_ready |-> code_pending)
		else $error("full but empty");
	a_empty_ready: assert property (!code_pending |-> word_ready)
		else $error("empty but full");
endmodule : sdp_top_sva
bind sdp_top sdp_top_sva sdp_top_sva_i (.clock(clock), .rst(rst),
	.sclk(sclk), .frame_n(frame_n), .serial_out(serial_out),
	.dac_code(dac_code), .code_ready(code_ready),
	.code_pending(code_pending), .word_ready(word_ready),
	.rise_edge_sel(rise_edge_sel), .daisy_mode(daisy_mode));

/* File: verif/sdp_host.sv */
`timescale 1ns/1ps
module sdp_host (
	output logic sclk,
	output logic frame_n,
	output logic serial_in,
	input wire logic serial_out
);
	initial begin
		sclk = 1'b0;
		frame_n = 1'b1;
		serial_in = 1'b0;
	end
	// clock stands still between frames; data moves on the inactive edge
	task automatic xfer(input logic [15:0] w, input logic act,
		output logic [15:0] r);
		sclk = act;
		#100 frame_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			#20 sclk = !act;
			serial_in = w[i];
			#80 r = {r[14:0], serial_out};
			sclk = act;
			#60;
		end
		#20 frame_n = 1'b1;
		// released line must not keep showing the last bit
		serial_in = !serial_in;
		#200;
	endtask : xfer
endmodule : sdp_host

/* File: verif/test_sdp_top.sv */
`timescale 1ns/1ps
module test_sdp_top;
	import sdp_pkg::*;
	logic clock, rst, sclk, frame_n, serial_in, serial_out, code_ready;
	logic code_pending, word_ready, rise_edge_sel, daisy_mode;
	logic [CODE_W-1:0] dac_code;
	logic [15:0] r;
	int mismatches = 0;
	int n_compared = 0;
	int cyc = 0;
	sdp_top #(.DEPTH(FIFO_DEPTH)) sdp_top_i (.clock(clock), .rst(rst),
		.sclk(sclk), .frame_n(frame_n), .serial_in(serial_in),
		.serial_out(serial_out), .dac_code(dac_code),
		.code_ready(code_ready), .code_pending(code_pending),
		.word_ready(word_ready), .rise_edge_sel(rise_edge_sel),
		.daisy_mode(daisy_mode));
	sdp_host sdp_host_i (.sclk(sclk), .frame_n(frame_n),
		.serial_in(serial_in), .serial_out(serial_out));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task check(input string n, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
		end
	endtask : check
	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	task drain(input logic [11:0] e);
		@(negedge clock) code_ready = 1'b1;
		for (int i = 0; i < 99 && code_pending; i++) @(negedge clock);
		repeat (3) @(negedge clock);
		code_ready = 1'b0;
		check("dac_code", {4'h0, dac_code}, {4'h0, e});
	endtask : drain
	always @(posedge clock) begin
		cyc++;
		if (cyc > 30000) begin
			mismatches++;
			end_of_test;
		end
	end
	initial begin
		rst = 1'b1;
		code_ready = 1'b0;
		repeat (4) @(negedge clock);
		rst = 1'b0;
		repeat (2) @(negedge clock);
		check("reset", {rise_edge_sel, daisy_mode, word_ready,
			code_pending, dac_code}, 16'h2000);
		sdp_host_i.xfer(16'h1abc, 1'b0, r);
		check("pending", {15'h0, code_pending}, 16'h0001);
		check("held", {4'h0, dac_code}, 16'h0000);
		drain(12'habc);
		sdp_host_i.xfer(16'h2000, 1'b0, r);
		sdp_host_i.xfer(16'h0123, 1'b0, r);
		check("readback", {4'h0, r[11:0]}, 16'h0abc);
		sdp_host_i.xfer(16'h0000, 1'b0, r);
		check("chain", {1'b0, r[14:0]}, 16'h0123);
		sdp_host_i.xfer(16'hb000, 1'b0, r);
		check("edge", {15'h0, rise_edge_sel}, 16'h0001);
		sdp_host_i.xfer(16'h1555, 1'b1, r);
		drain(12'h555);
		sdp_host_i.xfer(16'h8000, 1'b1, r);
		sdp_host_i.xfer(16'h1777, 1'b1, r);
		check("daisy", {15'h0, daisy_mode}, 16'h0001);
		drain(12'h777);
		sdp_host_i.xfer(16'h9000, 1'b1, r);
		check("daisy off", {15'h0, daisy_mode}, 16'h0000);
		sdp_host_i.xfer(16'ha000, 1'b1, r);
		check("edge off", {15'h0, rise_edge_sel}, 16'h0000);
		// one word past depth is dropped, so the last code is depth-1
		for (int i = 0; i <= FIFO_DEPTH; i++)
			sdp_host_i.xfer(16'h1000 + 16'(i), 1'b0, r);
		check("full", {15'h0, word_ready}, 16'h0000);
		drain(12'h01f);
		end_of_test;
	end
endmodule : test_sdp_top
